// ---- dv/sbtc_ext_src.sv ----
`timescale 1ns/1ps
module sbtc_ext_src (
  // Clock
  input wire logic core_clk,
  // Burst request
  input wire logic start,
  input wire logic pin_sel,
  input wire logic [7:0] n_pulse,
  // Pins and status
  output logic [1:0] pin_in,
  output logic busy
);
  // Idles low between bursts, so the first rise of a burst follows no falling edge
  initial begin
    pin_in = 2'h0;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (start) begin
        busy <= 1'b1;
        repeat (n_pulse) begin
          repeat (3) @(posedge core_clk);
          pin_in[pin_sel] <= 1'b1;
          repeat (3) @(posedge core_clk);
          pin_in[pin_sel] <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- dv/sbtc_timer_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module sbtc_timer_tb;
  import sbtc_pkg::*;
  localparam logic [5:0] OSC_TAB = 6'h0c;
  localparam logic [5:0] SB_TAB = 6'h25;
  localparam logic [5:0] SLP_TAB = 6'h30;
  logic core_clk, rst_n, sleep, trig_a, trig_b, irq, wake, start, pin_sel, busy;
  logic [7:0] rdata, d, n_pulse;
  logic [1:0] pin_in, pin_out, pin_oe;
  logic [31:0] rnd;
  logic [15:0] v, c, e, dd;
  sbtc_bus_type bus;
  int num_errors, total_checks, k;
  sbtc_timer i_sbtc_timer (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .sleep(sleep),
    .trig_a(trig_a), .trig_b(trig_b), .irq(irq), .wake(wake), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  sbtc_ext_src i_sbtc_ext_src (.core_clk(core_clk), .start(start), .pin_sel(pin_sel), .n_pulse(n_pulse),
    .pin_in(pin_in), .busy(busy));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask
  task automatic wcount(input logic [15:0] w);
    wr(ADDR_COUNT_LO, w[7:0]);
    wr(ADDR_COUNT_HI, w[15:8]);
  endtask
  task automatic rcount;
    rd(ADDR_COUNT_LO);
    c[7:0] = d;
    rd(ADDR_COUNT_HI);
    c[15:8] = d;
  endtask
  // Burst on one pin, then let a synchronised pending step land
  task automatic pulses(input logic sel);
    pin_sel <= sel;
    n_pulse <= 8'h09;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (k = 0; k < 200 && busy; k++) @(posedge core_clk);
    if (busy) begin
      num_errors++;
      print_verdict();
    end
    repeat (8) @(posedge core_clk);
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    bus = '0;
    sleep = 1'b0;
    trig_a = 1'b0;
    trig_b = 1'b0;
    start = 1'b0;
    pin_sel = 1'b0;
    n_pulse = 8'h00;
    num_errors = 0;
    total_checks = 0;
    rnd = 32'h2;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(ADDR_CONTROL);
    `CHK(d, 8'h00)
    rd(8'h00);
    `CHK(d, 8'h00)
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL);
    `CHK(d, 8'h3f)
    rnd = xs(rnd);
    v = rnd[15:0];
    wr(ADDR_CONTROL, 8'h00);
    wcount(v);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rcount();
    `CHK(c, v)
    for (int p = 0; p < 4; p++) begin
      rnd = xs(rnd);
      wcount(rnd[15:0]);
      wr(ADDR_CONTROL, {2'h0, p[1:0], 1'b0, rnd[16], 2'h1});
      repeat (256) @(posedge core_clk);
      wr(ADDR_CONTROL, 8'h00);
      rcount();
      dd = c - rnd[15:0];
      k = 64 >> p;
      `CHK(dd >= k - 1 && dd <= k + 1, 1'b1)
    end
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_FLAG, 8'h00);
    wcount(16'hfffd);
    wr(ADDR_CONTROL, 8'h01);
    repeat (40) @(posedge core_clk);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_FLAG);
    `CHK(d[0], 1'b1)
    `CHK(irq, 1'b0)
    rcount();
    `CHK(c[15:8], 8'h00)
    wr(ADDR_ENABLE, 8'h01);
    `CHK(irq, 1'b1)
    sleep <= 1'b1;
    @(posedge core_clk);
    #1 `CHK(wake, 1'b1)
    @(posedge core_clk);
    sleep <= 1'b0;
    wr(ADDR_FLAG, 8'h00);
    `CHK(irq, 1'b0)
    for (int t = 0; t < 2; t++) begin
      rnd = xs(rnd);
      wcount(rnd[15:0] | 16'h0001);
      trig_a <= (t == 0);
      trig_b <= (t == 1);
      @(posedge core_clk);
      trig_a <= 1'b0;
      trig_b <= 1'b0;
      rcount();
      `CHK(c, 16'h0000)
      rd(ADDR_FLAG);
      `CHK(d[0], 1'b0)
    end
    bus <= '{addr: ADDR_COUNT_LO, wdata: 8'h5a, wr: 1'b1, rd: 1'b0};
    trig_a <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
    trig_a <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_COUNT_LO);
    `CHK(d, 8'h5a)
    wr(ADDR_PORT_DATA, 8'h02);
    `CHK(pin_out, 2'h2)
    rd(ADDR_PORT_DATA);
    `CHK(d[1:0], pin_in)
    wr(ADDR_PORT_DIR, 8'h00);
    `CHK(pin_oe, 2'h3)
    wr(ADDR_CONTROL, 8'h08);
    `CHK(pin_oe, 2'h0)
    rd(ADDR_PORT_DATA);
    `CHK(d[1:0], 2'h0)
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CONTROL, 8'h00);
      wcount(16'h0000);
      sleep <= SLP_TAB[i];
      wr(ADDR_CONTROL, {4'h1, OSC_TAB[i], SB_TAB[i], 2'h3});
      e = (SLP_TAB[i] && !SB_TAB[i]) ? 16'h0000 : 16'h0004;
      pulses(OSC_TAB[i]);
      rcount();
      `CHK(c, e)
      pulses(!OSC_TAB[i]);
      rcount();
      `CHK(c, e)
    end
    print_verdict();
  end
endmodule

// ---- hdl/sbtc_pkg.sv ----
package sbtc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h0e;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h0f;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_ENABLE = 8'h11;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h12;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h13;
  // Control, flag and enable field positions
  localparam int CTL_RUN = 0;
  localparam int CTL_SRC = 1;
  localparam int CTL_SYNC = 2;
  localparam int CTL_OSC = 3;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_PS_HI = 5;
  localparam int FLAG_OVF = 0;
  localparam int EN_OVF = 0;
  // Reset values
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam logic [1:0] PORT_DIR_RESET = 2'h3;
  localparam logic [1:0] PORT_DATA_RESET = 2'h0;
  // Instruction cycle is the core clock divided by four
  localparam int INSTR_DIV = 4;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  typedef struct packed {
    logic run;
    logic src;
    logic sync_bypass;
    logic osc;
    logic [1:0] ps;
  } sbtc_ctrl_type;

  typedef struct packed {
    sbtc_ctrl_type ctrl;
    logic [15:0] count;
    logic flag;
    logic ie;
    logic [1:0] dir;
    logic [1:0] port_out;
    logic [1:0] div;
    logic [2:0] pre;
    logic armed;
    logic pend;
    logic prev_in;
    logic [7:0] rdata;
    // Per byte: set once the count byte holds a known value
    logic [1:0] seeded;
  } sbtc_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbtc_bus_type;
endpackage

// ---- hdl/sbtc_timer.sv ----
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - Sixteen-bit count held as high and low bytes, both read and written.
// - Counts up from all zeros to all ones, then wraps to zero.
// - Wrap from maximum to zero latches the overflow flag, flag register bit 0.
// - Interrupt request is the flag gated by enable register bit 0.
// - Source select clear picks the internal clock, core clock over four.
// - Internal mode advances once per instruction cycle through the prescaler.
// - Source select set counts rising edges of the external input.
// - Counts only while run enable is set; clearing it holds the value.
// - Either compare unit trigger clears the count.
// - Oscillator enable forces both pins to inputs, reading as zero.
// - Sync bit is ignored in internal clock mode.
// - External mode needs one falling edge before any rising edge counts.
// - External edges come from oscillator pin or external clock pin per enable.
// - Sync bit clear aligns the prescaler output to instruction cycles.
// - Prescaler counts the selected input, ahead of the sync stage.
// - Synchronised external mode in sleep freezes the count, prescaler still runs.
// - Sync bit set counts unsynchronised, runs in sleep, overflow can wake.
// - A compare trigger clear never sets the overflow flag.
// - A software count write beats a coinciding compare trigger clear.
// - Reset leaves both count bytes unchanged.
module sbtc_timer
  import sbtc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire sbtc_bus_type bus,
  output logic [7:0] rdata,
  // System
  input wire logic sleep,
  input wire logic trig_a,
  input wire logic trig_b,
  output logic irq,
  output logic wake,
  // Pins: bit 0 external clock pin, bit 1 oscillator input pin
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);

  sbtc_state_type s;
  sbtc_state_type next_s;

  logic instr_tick;
  logic sel_in;
  logic rise;
  logic fall;
  logic pre_in;
  logic pre_tick;
  logic cnt_inc;
  logic clr;
  logic wr_lo;
  logic wr_hi;
  logic [2:0] pre_mask;

  function automatic logic hit(input sbtc_bus_type b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  assign instr_tick = (s.div == 2'(INSTR_DIV - 1));
  assign sel_in = s.ctrl.osc ? pin_in[1] : pin_in[0];
  assign rise = sel_in & ~s.prev_in;
  assign fall = ~sel_in & s.prev_in;
  assign pre_mask = 3'((4'h1 << s.ctrl.ps) - 4'h1);
  assign wr_lo = hit(bus, ADDR_COUNT_LO);
  assign wr_hi = hit(bus, ADDR_COUNT_HI);
  assign clr = trig_a | trig_b;

  // Prescaler input: instruction cycles in timer mode, armed rising edges otherwise
  always_comb begin
    if (!s.ctrl.run) begin
      pre_in = 1'b0;
    end else if (!s.ctrl.src) begin
      pre_in = instr_tick & ~sleep;
    end else begin
      pre_in = rise & s.armed;
    end
  end

  assign pre_tick = pre_in && ((s.pre & pre_mask) == pre_mask);

  // Count step after the optional sync stage
  always_comb begin
    if (!s.ctrl.run) begin
      cnt_inc = 1'b0;
    end else if (!s.ctrl.src) begin
      cnt_inc = pre_tick;
    end else if (s.ctrl.sync_bypass) begin
      cnt_inc = pre_tick;
    end else begin
      cnt_inc = s.pend && instr_tick && !sleep;
    end
  end

  always_comb begin
    next_s = s;
    next_s.div = s.div + 2'h1;
    next_s.prev_in = sel_in;
    // Arming needs a falling edge after the counter enters external mode
    if (!s.ctrl.run || !s.ctrl.src) begin
      next_s.armed = 1'b0;
    end else if (fall) begin
      next_s.armed = 1'b1;
    end
    if (pre_in) begin
      next_s.pre = pre_tick ? 3'h0 : s.pre + 3'h1;
    end
    // Sync stage: only used in external synchronised mode, off in sleep
    if (!s.ctrl.src || s.ctrl.sync_bypass || sleep) begin
      next_s.pend = 1'b0;
    end else if (pre_tick) begin
      next_s.pend = 1'b1;
    end else if (cnt_inc) begin
      next_s.pend = 1'b0;
    end
    if (sleep && s.ctrl.src && !s.ctrl.sync_bypass && pre_tick) begin
      next_s.pend = 1'b0;
    end
    // Count update: write beats trigger clear beats increment
    if (wr_lo || wr_hi) begin
      if (wr_lo) begin
        next_s.count[7:0] = bus.wdata;
      end
      if (wr_hi) begin
        next_s.count[15:8] = bus.wdata;
      end
      next_s.pre = 3'h0;
      next_s.pend = 1'b0;
    end else if (clr) begin
      next_s.count = 16'h0000;
      next_s.pre = 3'h0;
    end else if (cnt_inc) begin
      next_s.count = s.count + 16'h0001;
    end
    // Overflow flag: software write first, hardware set wins
    if (hit(bus, ADDR_FLAG)) begin
      next_s.flag = bus.wdata[FLAG_OVF];
    end
    if (cnt_inc && !clr && !wr_lo && !wr_hi && s.count == COUNT_MAX) begin
      next_s.flag = 1'b1;
    end
    // Count bytes power up unknown; track which ones have been loaded
    if (wr_lo || clr) begin
      next_s.seeded[0] = 1'b1;
    end
    if (wr_hi || clr) begin
      next_s.seeded[1] = 1'b1;
    end
    if (hit(bus, ADDR_CONTROL)) begin
      next_s.ctrl.run = bus.wdata[CTL_RUN];
      next_s.ctrl.src = bus.wdata[CTL_SRC];
      next_s.ctrl.sync_bypass = bus.wdata[CTL_SYNC];
      next_s.ctrl.osc = bus.wdata[CTL_OSC];
      next_s.ctrl.ps = bus.wdata[CTL_PS_HI:CTL_PS_LO];
    end
    if (hit(bus, ADDR_ENABLE)) begin
      next_s.ie = bus.wdata[EN_OVF];
    end
    if (hit(bus, ADDR_PORT_DATA)) begin
      next_s.port_out = bus.wdata[1:0];
    end
    if (hit(bus, ADDR_PORT_DIR)) begin
      next_s.dir = bus.wdata[1:0];
    end
    // Read data stands in the cycle after the strobe only
    next_s.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_FLAG: next_s.rdata = {7'h00, s.flag};
        ADDR_COUNT_LO: next_s.rdata = s.count[7:0];
        ADDR_COUNT_HI: next_s.rdata = s.count[15:8];
        ADDR_CONTROL: next_s.rdata = {2'h0, s.ctrl};
        ADDR_ENABLE: next_s.rdata = {7'h00, s.ie};
        ADDR_PORT_DATA: next_s.rdata = {6'h00, s.ctrl.osc ? 2'h0 : pin_in};
        ADDR_PORT_DIR: next_s.rdata = {6'h00, s.dir};
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '{ctrl: CONTROL_RESET, count: s.count, flag: 1'b0, ie: 1'b0, dir: PORT_DIR_RESET,
             port_out: PORT_DATA_RESET, div: 2'h0, pre: 3'h0, armed: 1'b0, pend: 1'b0,
             prev_in: 1'b0, rdata: 8'h00, seeded: 2'h0};
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign irq = s.flag & s.ie;
  assign wake = irq & sleep;
  assign pin_out = s.port_out;
  assign pin_oe = s.ctrl.osc ? 2'h0 : ~s.dir;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_overflow_step;
    cnt_inc && !clr && !wr_lo && !wr_hi && s.count == COUNT_MAX;
  endsequence

  sequence s_wrapped;
    s.count == 16'h0000 && s.flag;
  endsequence

  a_wrap_sets_flag: assert property (s_overflow_step |=> s_wrapped)
    else $error("overflow did not wrap and set flag");
  a_irq_gated: assert property (irq == (s.flag && s.ie))
    else $error("interrupt not gated by enable");
  a_stopped_holds: assert property (!s.ctrl.run && &s.seeded && !wr_lo && !wr_hi && !clr
                                    |=> s.count == $past(s.count))
    else $error("count moved while stopped");
  a_clear_no_flag: assert property (clr && !wr_lo && !wr_hi && !s.flag && !hit(bus, ADDR_FLAG)
                                    |=> s.count == 16'h0000 && !s.flag)
    else $error("trigger clear failed or set flag");
  a_write_wins: assert property (wr_lo && clr |=> s.count[7:0] == $past(bus.wdata))
    else $error("write lost against trigger clear");
  a_osc_pins_in: assert property (s.ctrl.osc |-> pin_oe == 2'h0)
    else $error("pin driven with oscillator enabled");
  a_osc_reads_zero: assert property (s.ctrl.osc && bus.rd && bus.addr == ADDR_PORT_DATA
                                     && !hit(bus, ADDR_CONTROL) |=> rdata == 8'h00)
    else $error("pin read not zero with oscillator enabled");
  a_unarmed_no_count: assert property (s.ctrl.src && !s.armed |-> !pre_in)
    else $error("edge counted before falling edge");
  a_sleep_sync_hold: assert property (s.ctrl.run && s.ctrl.src && !s.ctrl.sync_bypass && sleep
                                      && !wr_lo && !wr_hi && !clr |=> $stable(s.count))
    else $error("synchronised count moved in sleep");
  a_timer_rate: assert property (s.ctrl.run && !s.ctrl.src && !sleep && s.ctrl.ps == 2'h0
                                 && instr_tick && !wr_lo && !wr_hi && !clr
                                 |=> s.count == $past(s.count) + 16'h0001)
    else $error("timer did not step on instruction cycle");
  a_inc_by_one: assert property (cnt_inc && !wr_lo && !wr_hi && !clr
                                 |=> s.count == 16'($past(s.count) + 16'h0001))
    else $error("count did not step by one");

  // The reset and low-byte read checks on the count wait until the bytes hold known values
  a_reset_keeps: assert property (disable iff (1'b0) !rst_n && &s.seeded
                                  |=> s.count == $past(s.count))
    else $error("reset changed the count");
  a_flag_set_wins: assert property (cnt_inc && !clr && !wr_lo && !wr_hi && s.count == COUNT_MAX
                                    && hit(bus, ADDR_FLAG) |=> s.flag)
    else $error("flag write beat the overflow set");
  a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data stood without a read");
  a_read_lo: assert property (bus.rd && bus.addr == ADDR_COUNT_LO && s.seeded[0]
                              |=> rdata == $past(s.count[7:0]))
    else $error("low count byte read wrong");
  a_timer_no_pend: assert property (!s.ctrl.src |=> !s.pend)
    else $error("sync stage active in timer mode");
  a_sync_on_tick: assert property (s.ctrl.src && !s.ctrl.sync_bypass && cnt_inc
                                   |-> instr_tick && !sleep)
    else $error("synchronised step off the instruction cycle");
  a_trig_b_clears: assert property (trig_b && !wr_lo && !wr_hi |=> s.count == 16'h0000)
    else $error("second trigger did not clear the count");
  a_ext_rise_only: assert property (s.ctrl.src && pre_in |-> rise && s.armed)
    else $error("external step without an armed rising edge");
  a_ps_top_ratio: assert property (s.ctrl.run && s.ctrl.ps == 2'h3 && pre_tick |-> s.pre == 3'h7)
    else $error("divide by eight stepped early");

endmodule
